// ===== busgrant_pkg.sv
// Package for the external bus request/grant block: states and carriers.
// Assumes one processor clock domain and a synchronous active-low reset.
package busgrant_pkg;

   // Reset levels of the active-low memory strobes and the grant.
   localparam logic STROBE_IDLE = 1'b1;
   localparam logic GRANT_IDLE = 1'b1;
   // Depth of the request synchroniser.
   localparam int SYNC_STAGES = 2;

   typedef enum logic [1:0] {
      OWN_BUS,
      RELEASE,
      GRANTED,
      RECLAIM
   } arb_state_e;

   // Memory strobes that the core drives while it owns the bus.
   typedef struct packed {
      logic data_mem_select_n;
      logic program_mem_select_n;
      logic boot_mem_select_n;
      logic read_n;
      logic write_n;
   } mem_strobes_s;

   localparam mem_strobes_s STROBES_IDLE = '{
      data_mem_select_n: 1'b1,
      program_mem_select_n: 1'b1,
      boot_mem_select_n: 1'b1,
      read_n: 1'b1,
      write_n: 1'b1
   };

endpackage

// ===== req_sync.sv
// Two-stage synchroniser for the asynchronous bus request pin.
// Assumes the input may change at any time relative to clk.
module req_sync
   import busgrant_pkg::*;
(
   // Clock and reset.
   input wire logic clk,
   input wire logic resetn,
   // Pin and synchronised level.
   input wire logic async_in,
   output logic sync_out
);

   logic meta_q;
   logic sync_q;

   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         meta_q <= 1'b1;
         sync_q <= 1'b1;
      end
      else
      begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end

   assign sync_out = sync_q;

endmodule // req_sync

// ===== bus_grant.sv
// External memory bus request/grant arbiter of the processor core.
// Assumes CLK is the processor clock and the request pin is asynchronous.
// Operation
// - A request meeting the sampling window counts this cycle, else next; here it counts one cycle later, after the synchroniser.
// - The grant goes low in the cycle after the request was recognised; here it falls two cycles after, following a release cycle.
// - The request is synchronised inside; no outside synchroniser needed.
// - Selects and strobes are released no later than the grant goes low.
// - Selects and strobes are driven again only once the grant is high.
module bus_grant
   import busgrant_pkg::*;
(
   // Clock and reset.
   input wire logic CLK,
   input wire logic RESETN,
   // Outside bus master.
   input wire logic BUS_REQUEST_N,
   output logic BUS_GRANT_N,
   // Core memory strobes in.
   input wire mem_strobes_s CORE_STROBES,
   // Memory strobe pins and the one output enable they share.
   output mem_strobes_s STROBES_OUT,
   output logic STROBES_OE,
   // Clock output seen by the requester.
   output logic PROCESSOR_CLOCK_OUT,
   // High while the core must hold off memory accesses.
   output logic CORE_STALL
);

   // Width of the strobe bundle, one flop per pin.
   localparam int STROBE_BITS = $bits(mem_strobes_s);

   arb_state_e state_q;
   arb_state_e state_d;
   logic req_seen_n;
   logic req_active;
   logic next_own;
   logic next_granted;
   logic grant_n_q;
   logic grant_n_d;
   logic oe_q;
   logic oe_d;
   logic clk_div_q;
   logic clk_div_d;
   logic [STROBE_BITS-1:0] core_bits;
   logic [STROBE_BITS-1:0] idle_bits;
   logic [STROBE_BITS-1:0] pin_bits_q;

   // The pin is asynchronous, so it passes two flops before any decode.
   // Recognition therefore lands one edge after the pin is first sampled.
   req_sync u_req_sync (
      .clk(CLK),
      .resetn(RESETN),
      .async_in(BUS_REQUEST_N),
      .sync_out(req_seen_n)
   );

   // A low synchronised level means the outside master wants the bus.
   assign req_active = !req_seen_n;

   // The arbiter walks own, release, granted and reclaim in that order.
   // Release and reclaim each last one cycle, so the pins never overlap.
   always_comb
   begin
      state_d = state_q;
      case (state_q)
         OWN_BUS:
         begin
            if (req_active)
            begin
               state_d = RELEASE;
            end
         end
         RELEASE:
         begin
            state_d = GRANTED;
         end
         GRANTED:
         begin
            if (!req_active)
            begin
               state_d = RECLAIM;
            end
         end
         RECLAIM:
         begin
            state_d = OWN_BUS;
         end
         default:
         begin
            state_d = OWN_BUS;
         end
      endcase
   end

   // Decodes of the next state feed the registered pin levels.
   assign next_own = (state_d == OWN_BUS);
   assign next_granted = (state_d == GRANTED);

   // The grant drops on entry to GRANTED, one cycle after the release.
   assign grant_n_d = next_granted ? 1'b0 : GRANT_IDLE;

   // Strobes stay released until one cycle after the grant is back high.
   // That spare cycle keeps both masters off the pins during handover.
   assign oe_d = next_own;

   assign clk_div_d = ~clk_div_q;
   assign core_bits = CORE_STROBES;
   assign idle_bits = STROBES_IDLE;

   // Arbiter state register.
   always_ff @(posedge CLK)
   begin
      if (!RESETN)
      begin
         state_q <= OWN_BUS;
      end
      else
      begin
         state_q <= state_d;
      end
   end

   // Grant register; the pin is idle high out of reset.
   always_ff @(posedge CLK)
   begin
      if (!RESETN)
      begin
         grant_n_q <= GRANT_IDLE;
      end
      else
      begin
         grant_n_q <= grant_n_d;
      end
   end

   // Output enable of the strobe pins; the core owns the bus after reset.
   always_ff @(posedge CLK)
   begin
      if (!RESETN)
      begin
         oe_q <= 1'b1;
      end
      else
      begin
         oe_q <= oe_d;
      end
   end

   // Clock output toggles on every rising CLK edge and starts low after reset.
   always_ff @(posedge CLK)
   begin
      if (!RESETN)
      begin
         clk_div_q <= 1'b0;
      end
      else
      begin
         clk_div_q <= clk_div_d;
      end
   end

   // Each strobe pin has its own flop, loaded from the core or parked.
   // Parking at the idle level in the same edge as the enable drops means
   // no pin shows a live strobe while the grant is low.
   genvar i;
   generate
      for (i = 0; i < STROBE_BITS; i++)
      begin : g_strobe
         always_ff @(posedge CLK)
         begin
            if (!RESETN)
            begin
               pin_bits_q[i] <= idle_bits[i];
            end
            else if (oe_d)
            begin
               pin_bits_q[i] <= core_bits[i];
            end
            else
            begin
               pin_bits_q[i] <= idle_bits[i];
            end
         end
      end
   endgenerate

   assign BUS_GRANT_N = grant_n_q;
   assign STROBES_OUT = mem_strobes_s'(pin_bits_q);
   assign STROBES_OE = oe_q;
   assign PROCESSOR_CLOCK_OUT = clk_div_q;

   // Stall rises with recognition so the core never starts a lost cycle.
   assign CORE_STALL = !oe_d;

endmodule // bus_grant

// ===== bus_grant_sva.sv
// Assertions on the bus_grant pins, bound at the foot of this file.
// Assumes one clock and a synchronous active-low reset.
module bus_grant_chk import busgrant_pkg::*; (
   input wire logic CLK,
   input wire logic RESETN,
   input wire logic BUS_REQUEST_N,
   input wire logic BUS_GRANT_N,
   input wire mem_strobes_s STROBES_OUT,
   input wire logic STROBES_OE);
   default clocking @(posedge CLK); endclocking
   default disable iff (!RESETN);
   sequence idle_req;
      (BUS_GRANT_N && STROBES_OE && BUS_REQUEST_N) ##1 (!BUS_REQUEST_N)[*4];
   endsequence
   a_grant_due: assert property (idle_req |-> ##2 !BUS_GRANT_N)
      else $error("grant late");
   a_grant_not_early: assert property ($fell(BUS_GRANT_N) |->
      !$past(STROBES_OE) && !$past(BUS_REQUEST_N, 4)) else $error("early");
   a_strobes_idle: assert property (!STROBES_OE |->
      STROBES_OUT == STROBES_IDLE) else $error("strobes driven");
   a_reclaim_late: assert property ($rose(STROBES_OE) |->
      BUS_GRANT_N && $past(BUS_GRANT_N)) else $error("strobes early");
   a_grant_holds: assert property ((!BUS_REQUEST_N)[*4]
      ##0 !BUS_GRANT_N |=> !BUS_GRANT_N) else $error("grant lost");
   a_grant_drops: assert property (BUS_REQUEST_N[*5] |-> BUS_GRANT_N)
      else $error("grant kept");
endmodule // bus_grant_chk
bind bus_grant bus_grant_chk chk_u (.CLK, .RESETN, .BUS_REQUEST_N,
   .BUS_GRANT_N, .STROBES_OUT, .STROBES_OE);

// ===== master_model.sv
// Model of the outside master that asks for the memory bus.
// Assumes need comes from the bench; the pin moves 37 ns after an edge.
module master_model (
   input wire logic clk,
   input wire logic need,
   output logic bus_request_n = 1'b1);
   timeunit 1ns / 1ns;
   always @(posedge clk) bus_request_n <= #37 !need;
endmodule // master_model

// ===== bus_grant_bench.sv
// Bench for bus_grant, driven through the outside master model.
// Assumes the checker binds itself to bus_grant.
module bus_grant_bench import busgrant_pkg::*; ;
   timeunit 1ns / 1ns;
   logic clk = 1'b0, resetn = 1'b0, need = 1'b0, req_n, gnt_n, oe;
   logic stall, ck;
   mem_strobes_s core = STROBES_IDLE, pins;
   int err_total = 0, comparisons = 0, n;
   always #50 clk = ~clk;
   master_model bm_u (.clk(clk), .need(need), .bus_request_n(req_n));
   bus_grant dut_u (.CLK(clk), .RESETN(resetn), .BUS_REQUEST_N(req_n),
      .BUS_GRANT_N(gnt_n), .CORE_STROBES(core), .STROBES_OUT(pins),
      .STROBES_OE(oe), .PROCESSOR_CLOCK_OUT(ck), .CORE_STALL(stall));
   task automatic chk(string nm, logic [5:0] exp, logic [5:0] got);
      comparisons++;
      err_total += int'(got !== exp);
      if (got !== exp) $display("BAD %s exp %h got %h", nm, exp, got);
   endtask
   task automatic results();
      if (err_total == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // Counts falling edges until the grant reaches lvl; gives up after 21.
   task automatic wait_gnt(logic lvl, logic [5:0] exp);
      for (n = 0; n <= 20 && gnt_n !== lvl; n++) @(negedge clk);
      chk("delay", exp, n[5:0]);
      if (n > 20) results();
   endtask
   task automatic do_reset();
      @(posedge clk);
      resetn <= 1'b0;
      @(posedge clk);
      @(negedge clk);
      chk("rst", {1'b1, STROBES_IDLE}, {oe, pins});
      chk("rst_gnt", 6'h02, {4'h0, gnt_n, ck});
      @(posedge clk);
      resetn <= 1'b1;
      @(negedge clk);
      chk("ck_low", 6'h00, {5'h00, ck});
      @(negedge clk);
      chk("ck_high", 6'h01, {5'h00, ck});
   endtask
   task automatic cycle_bus(int hold, mem_strobes_s nxt);
      @(posedge clk);
      need <= 1'b1;
      wait_gnt(1'b0, 6'h06);
      chk("off", {1'b0, STROBES_IDLE}, {oe, pins});
      chk("stall", 6'h01, {5'h00, stall});
      repeat (hold) @(negedge clk);
      chk("held", 6'h00, {5'h00, gnt_n});
      @(posedge clk);
      core <= nxt;
      need <= 1'b0;
      wait_gnt(1'b1, 6'h05);
      chk("late", 6'h00, {5'h00, oe});
      @(negedge clk);
      chk("on", {1'b1, nxt}, {oe, pins});
      chk("run", 6'h00, {5'h00, stall});
   endtask
   initial
   begin
      do_reset();
      cycle_bus(1, 5'h0A);
      do_reset();
      cycle_bus(20, 5'h15);
      results();
   end
endmodule // bus_grant_bench
